// ### adc_extra_map.vh
// offsets, field positions, reset values and codes of the extra conversion control
// assumes: included by the design files by bare name
`ifndef ADC_EXTRA_MAP_VH
`define ADC_EXTRA_MAP_VH
// ****************************************
// register map
// ****************************************
// register indices: the bus byte address is four times the index
`define EXTRA_CTRL_OFFSET 8'hb6
`define EXTRA_STATUS_OFFSET 8'hba
`define EXTRA_CTRL_RESET 8'h00
// ****************************************
// field positions
// ****************************************
`define REF_HI 7
`define REF_LO 6
`define DEC_HI 5
`define DEC_LO 4
`define CH_HI 3
`define CH_LO 0
// ****************************************
// decimation rates
// ****************************************
`define DEC_RATE_64 10'h040
`define DEC_RATE_128 10'h080
`define DEC_RATE_256 10'h100
`define DEC_RATE_512 10'h200
// ****************************************
// channel codes of note
// ****************************************
`define CH_LAST_SINGLE 4'h7
`define CH_FIRST_DIFF 4'h8
`define CH_LAST_DIFF 4'hb
`define CH_GND 4'hc
`define CH_POS_REF 4'hd
`define CH_TEMP 4'he
`define CH_VDD_THIRD 4'hf
`endif

// ### extra_channel_decode.v
// decodes the four-bit extra channel code into input selects
// assumes: combinational, fed from the control register of the same clock
`timescale 1ns/1ps
`default_nettype none
`include "adc_extra_map.vh"
module extra_channel_decode (
    input wire [3:0] code, // channel code
    output reg [7:0] single_sel, // one-hot single-ended input
    output reg [3:0] diff_sel, // one-hot differential pair
    output reg gnd_sel, // ground
    output reg pos_ref_sel, // positive reference
    output reg temp_sel, // temperature sensor
    output reg vdd_third_sel // one third of supply
);
    // one-hot decode; exactly one select is high per code
    always @* begin
        single_sel = 8'h00;
        diff_sel = 4'h0;
        gnd_sel = 1'b0;
        pos_ref_sel = 1'b0;
        temp_sel = 1'b0;
        vdd_third_sel = 1'b0;
        if (code <= `CH_LAST_SINGLE) begin
            single_sel[code[2:0]] = 1'b1;
        end else if (code <= `CH_LAST_DIFF) begin
            diff_sel[code[1:0]] = 1'b1;
        end else begin
            case (code)
                `CH_GND: gnd_sel = 1'b1;
                `CH_POS_REF: pos_ref_sel = 1'b1;
                `CH_TEMP: temp_sel = 1'b1;
                default: vdd_third_sel = 1'b1;
            endcase
        end
    end
endmodule // extra_channel_decode
`default_nettype wire

// ### adc_extra_conversion_control.v
// control register and request logic for the one-off extra conversion
// assumes: axi4-lite master on aclk; converter core reports busy as a level, sequence end and done as same-clock pulses
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_extra_map.vh"
module adc_extra_conversion_control (
    input wire aclk, // system clock, 40 MHz
    input wire aresetn, // synchronous reset, active low
    input wire [9:0] s_axi_awaddr, // write byte address, word aligned
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // byte enables
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [9:0] s_axi_araddr, // read byte address, word aligned
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire adc_busy, // converter running
    input wire seq_done, // sequence finished pulse
    input wire extra_done, // extra conversion finished pulse
    output reg extra_start, // start extra conversion pulse
    output reg extra_pending, // extra conversion armed
    output reg [1:0] extra_reference_select, // reference code
    output reg [1:0] extra_decimation_select, // decimation code
    output reg [9:0] extra_decimation_rate, // decimation in samples
    output reg [3:0] extra_channel_select, // channel code
    output reg [7:0] single_sel, // single-ended input select
    output reg [3:0] diff_sel, // differential pair select
    output reg gnd_sel, // ground select
    output reg pos_ref_sel, // positive reference select
    output reg temp_sel, // temperature sensor select
    output reg vdd_third_sel // supply third select
);
    localparam [1:0] RESP_OKAY = 2'b00;
    localparam [1:0] RESP_SLVERR = 2'b10;
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_RUN = 2'b01;

    reg [7:0] ctrl_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg aw_got_r;
    reg w_got_r;
    reg [9:0] awaddr_r;
    reg [7:0] wdata_r;
    reg wstrb0_r;
    wire ch_write;
    wire do_write;
    wire [7:0] sel_single;
    wire [3:0] sel_diff;
    wire sel_gnd;
    wire sel_ref;
    wire sel_temp;
    wire sel_vdd;
    reg launch;

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    // address and data latched separately so either may come first
    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = !w_got_r && !s_axi_bvalid;
    assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;
    // word index sits above the two byte-lane bits
    assign ch_write = do_write && wstrb0_r && (awaddr_r[9:2] == `EXTRA_CTRL_OFFSET);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 10'h000;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r[9:2] == `EXTRA_CTRL_OFFSET) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    assign s_axi_arready = !s_axi_rvalid;

    // status word shows the block's own state: armed and running
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (s_axi_araddr[9:2] == `EXTRA_CTRL_OFFSET) begin
                s_axi_rdata <= {24'h00_0000, ctrl_r};
            end else if (s_axi_araddr[9:2] == `EXTRA_STATUS_OFFSET) begin
                s_axi_rdata <= {24'h00_0000, 6'h00, state_r == ST_RUN, extra_pending};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // extra conversion sequencing
    // ****************************************
    // launch: idle write starts at once, else wait for sequence end or an idle converter
    always @* begin
        state_nxt = state_r;
        launch = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (ch_write && !adc_busy) begin
                    launch = 1'b1;
                end else if (extra_pending && !ch_write && (seq_done || !adc_busy)) begin
                    launch = 1'b1;
                end
                if (launch) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (extra_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // control register; a new channel write wins over the done clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `EXTRA_CTRL_RESET;
            state_r <= ST_IDLE;
            extra_pending <= 1'b0;
            extra_start <= 1'b0;
        end else begin
            state_r <= state_nxt;
            extra_start <= launch;
            if (launch) begin
                extra_pending <= 1'b0;
            end
            if (state_r == ST_RUN && extra_done) begin
                ctrl_r[`CH_HI:`CH_LO] <= 4'h0;
            end
            if (ch_write) begin
                ctrl_r <= wdata_r;
                extra_pending <= !(!adc_busy && state_r == ST_IDLE);
            end
        end
    end

    // ****************************************
    // outputs toward the converter core
    // ****************************************
    extra_channel_decode u_decode (
        .code(ctrl_r[`CH_HI:`CH_LO]),
        .single_sel(sel_single),
        .diff_sel(sel_diff),
        .gnd_sel(sel_gnd),
        .pos_ref_sel(sel_ref),
        .temp_sel(sel_temp),
        .vdd_third_sel(sel_vdd)
    );

    // registered so the analog side sees settled selects
    always @(posedge aclk) begin
        if (!aresetn) begin
            extra_reference_select <= 2'b00;
            extra_decimation_select <= 2'b00;
            extra_decimation_rate <= `DEC_RATE_64;
            extra_channel_select <= 4'h0;
            single_sel <= 8'h00;
            diff_sel <= 4'h0;
            gnd_sel <= 1'b0;
            pos_ref_sel <= 1'b0;
            temp_sel <= 1'b0;
            vdd_third_sel <= 1'b0;
        end else begin
            extra_reference_select <= ctrl_r[`REF_HI:`REF_LO];
            extra_decimation_select <= ctrl_r[`DEC_HI:`DEC_LO];
            case (ctrl_r[`DEC_HI:`DEC_LO])
                2'b00: extra_decimation_rate <= `DEC_RATE_64;
                2'b01: extra_decimation_rate <= `DEC_RATE_128;
                2'b10: extra_decimation_rate <= `DEC_RATE_256;
                default: extra_decimation_rate <= `DEC_RATE_512;
            endcase
            extra_channel_select <= ctrl_r[`CH_HI:`CH_LO];
            single_sel <= sel_single;
            diff_sel <= sel_diff;
            gnd_sel <= sel_gnd;
            pos_ref_sel <= sel_ref;
            temp_sel <= sel_temp;
            vdd_third_sel <= sel_vdd;
        end
    end
endmodule // adc_extra_conversion_control
`default_nettype wire

// ### adc_extra_checker.sv
// checks on the extra conversion control ports
// assumes: bound into the block; converter strobes last one cycle
`timescale 1ns/1ps
`default_nettype none
module adc_extra_checker (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic s_axi_bvalid, // write answer
    input wire logic seq_done, // sequence end
    input wire logic extra_done, // extra end
    input wire logic extra_start, // launch
    input wire logic extra_pending, // armed
    input wire logic [1:0] extra_decimation_select, // rate code
    input wire logic [9:0] extra_decimation_rate, // rate
    input wire logic [3:0] extra_channel_select, // channel
    input wire logic [3:0] diff_sel, // pair
    input wire logic gnd_sel // ground
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rate_map_a:
        assert property (extra_decimation_rate == (10'h040 << extra_decimation_select)) else $error("rate");
    pair_map_a:
        assert property (extra_channel_select[3:2] == 2'b10 |-> diff_sel == (4'h1 << extra_channel_select[1:0]))
            else $error("pair");
    gnd_map_a:
        assert property (gnd_sel == (extra_channel_select == 4'hc)) else $error("ground");
    start_pulse_a:
        assert property (extra_start |=> !extra_start) else $error("start length");
    start_cause_a:
        assert property (extra_start |-> $past(extra_pending) || $rose(s_axi_bvalid)) else $error("start cause");
    seq_launch_a:
        assert property (extra_pending && seq_done |-> ##[1:2] extra_start) else $error("no launch");
    // a write landing on the same edge as the end wins, so skip that case
    done_clear_a:
        assert property (extra_done ##1 !$rose(s_axi_bvalid) |=> extra_channel_select == 4'h0) else $error("no clear");
    idle_seq_a:
        assert property (seq_done && !extra_pending ##1 !$rose(s_axi_bvalid) |-> !extra_start) else $error("stray");
    cover property (extra_pending && seq_done);
    cover property (extra_done);
    cover property (extra_start && !extra_pending);
endmodule // adc_extra_checker
bind adc_extra_conversion_control adc_extra_checker chk_i (.aclk, .aresetn, .s_axi_bvalid, .seq_done, .extra_done,
    .extra_start, .extra_pending, .extra_decimation_select, .extra_decimation_rate, .extra_channel_select,
    .diff_sel, .gnd_sel);
`default_nettype wire

// ### adc_core_model.sv
// converter core stand-in: a sequence or one extra conversion
// assumes: same clock; bench pulses run_seq
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic extra_start, // launch
    input wire logic run_seq, // sequence
    input wire logic [7:0] conv_len, // length
    output logic adc_busy, // running
    output logic seq_done, // sequence end
    output logic extra_done // extra end
);
    // ****
    // timer
    // ****
    logic [7:0] cnt_r;
    logic xtr_r;
    // a launch while busy is dropped, as the real core would
    always @(posedge aclk) begin
        seq_done <= 1'b0;
        extra_done <= 1'b0;
        if (!aresetn) begin
            adc_busy <= 1'b0;
        end else if (adc_busy) begin
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h00) begin
                adc_busy <= 1'b0;
                seq_done <= !xtr_r;
                extra_done <= xtr_r;
            end
        end else if (run_seq || extra_start) begin
            adc_busy <= 1'b1;
            cnt_r <= conv_len;
            xtr_r <= extra_start;
        end
    end
endmodule // adc_core_model
`default_nettype wire

// ### adc_extra_conversion_control_tb_top.sv
// bench: bus tasks, converter stand-in, checks
// assumes: design, checker and model compiled first
`timescale 1ns/1ps
`default_nettype none
module adc_extra_conversion_control_tb_top;
    // ****
    // signals and instances
    // ****
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, run_seq = 1'b0;
    logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [7:0] conv_len = 8'h14, v;
    // byte addresses: control index 0xb6 and status index 0xba, four bytes per index
    localparam logic [9:0] CTRL_ADDR = 10'h2d8;
    localparam logic [9:0] STAT_ADDR = 10'h2e8;
    logic [31:0] s_axi_wdata = 32'h0000_0000, rdv;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] resp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, adc_busy, seq_done, extra_done;
    wire extra_start, extra_pending, gnd_sel, pos_ref_sel, temp_sel, vdd_third_sel;
    wire [1:0] s_axi_bresp, s_axi_rresp, extra_reference_select, extra_decimation_select;
    wire [31:0] s_axi_rdata;
    wire [9:0] extra_decimation_rate;
    wire [3:0] extra_channel_select, diff_sel;
    wire [7:0] single_sel;
    int bad_count = 0, n_tests = 0, cyc = 0, starts = 0, n;
    always #12.5 aclk = ~aclk;
    adc_extra_conversion_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_busy,
        .seq_done, .extra_done, .extra_start, .extra_pending, .extra_reference_select, .extra_decimation_select,
        .extra_decimation_rate, .extra_channel_select, .single_sel, .diff_sel, .gnd_sel, .pos_ref_sel, .temp_sel,
        .vdd_third_sel);
    adc_core_model conv (.aclk, .aresetn, .extra_start, .run_seq, .conv_len, .adc_busy, .seq_done, .extra_done);
    // count launches; a hang ends the run
    always @(posedge aclk) begin
        cyc++;
        if (extra_start === 1'b1)
            starts++;
        if (cyc == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d bad %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // both channels offered together, each dropped once taken
    task automatic axw(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [9:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        resp = s_axi_rresp;
        rdv = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    task automatic run_sequence();
        run_seq <= 1'b1;
        @(posedge aclk);
        run_seq <= 1'b0;
        while (seq_done !== 1'b1) @(posedge aclk);
        repeat (4) @(posedge aclk);
    endtask
    // every code of all three fields, then sequence and refusal cases
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axr(CTRL_ADDR);
        chk(rdv, 32'h0000_0000);
        for (int c = 0; c < 16; c++) begin
            n = starts;
            v = {c[1:0], c[3:2], c[3:0]};
            axw(CTRL_ADDR, v, 4'h1);
            chk(resp, 2'h0);
            repeat (2) @(posedge aclk);
            chk(starts, n + 1);
            chk(extra_reference_select, c[1:0]);
            chk(extra_decimation_select, c[3:2]);
            chk(extra_decimation_rate, 32'h0000_0040 << c[3:2]);
            chk(extra_channel_select, c[3:0]);
            chk(single_sel, (c < 8) ? 32'h0000_0001 << c : 32'h0000_0000);
            chk(diff_sel, (c[3:2] == 2) ? 32'h0000_0001 << c[1:0] : 32'h0000_0000);
            chk({gnd_sel, pos_ref_sel, temp_sel, vdd_third_sel}, {c == 12, c == 13, c == 14, c == 15});
            axr(CTRL_ADDR);
            chk(rdv, v);
            // status while the extra conversion runs: running set, nothing armed
            axr(STAT_ADDR);
            chk(resp, 2'h0);
            chk(rdv, 32'h0000_0002);
            while (extra_done !== 1'b1) @(posedge aclk);
            repeat (3) @(posedge aclk);
            axr(CTRL_ADDR);
            chk(rdv, v & 8'hf0);
        end
        // sequence request is a single-cycle pulse, else the core restarts it forever
        run_seq <= 1'b1;
        @(posedge aclk);
        run_seq <= 1'b0;
        n = starts;
        axw(CTRL_ADDR, 8'h03, 4'h1);
        chk(extra_pending, 1'b1);
        chk(starts, n);
        axr(STAT_ADDR);
        chk(rdv, 32'h0000_0001);
        while (seq_done !== 1'b1) @(posedge aclk);
        repeat (4) @(posedge aclk);
        chk(starts, n + 1);
        while (extra_done !== 1'b1) @(posedge aclk);
        run_sequence();
        chk(starts, n + 1);
        axw(CTRL_ADDR, 8'hff, 4'h0);
        chk(resp, 2'h0);
        axw(10'h040, 8'h05, 4'h1);
        chk(resp, 2'h2);
        axr(10'h040);
        chk(resp, 2'h2);
        chk(rdv, 32'h0000_0000);
        axr(CTRL_ADDR);
        chk(rdv, 32'h0000_0000);
        repeat (4) @(posedge aclk);
        chk(starts, n + 1);
        report_and_stop();
    end
endmodule // adc_extra_conversion_control_tb_top
`default_nettype wire
